//--- hw/bit_literal_op_decoder.sv
`timescale 1ns/1ps
// Function
// - bit clear and set, flags untouched
// - bit tests skip on low or high
// - taken skip or branch adds nop cycle
// - add immediate sets carry, digit carry, zero
// - and immediate updates zero only
// - and with file, destination bit selects target
// - add with file, destination, three flags
// - or immediate updates zero only
// - xor immediate updates zero only
// - immediate minus accumulator, three flags
// - return loads literal, two cycles
// - standby word sets time-out, clears power-down
// - port self-modify reads pin levels
// - timer zero write clears assigned prescaler
// - instruction cycle is four clocks
module bit_literal_op_decoder
    import bit_literal_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // program memory
    input wire logic [bit_literal_pkg::INSTR_W-1:0] instr_i,
    output logic [bit_literal_pkg::PC_W-1:0] pc_o,
    // file register access
    output logic [bit_literal_pkg::FA_W-1:0] file_raddr_o,
    input wire logic [bit_literal_pkg::DATA_W-1:0] file_rdata_i,
    output logic file_we_o,
    output logic [bit_literal_pkg::FA_W-1:0] file_waddr_o,
    output logic [bit_literal_pkg::DATA_W-1:0] file_wdata_o,
    // port pin levels from outside
    input wire logic [bit_literal_pkg::DATA_W-1:0] port_a_pins_i,
    input wire logic [bit_literal_pkg::DATA_W-1:0] port_b_pins_i,
    // return address stack
    output logic stack_push_o,
    output logic stack_pop_o,
    output logic [bit_literal_pkg::PC_W-1:0] return_addr_o,
    input wire logic [bit_literal_pkg::PC_W-1:0] stack_top_i,
    // timer and watchdog
    input wire logic prescaler_on_timer_i,
    output logic prescaler_clr_o,
    output logic watchdog_kick_o,
    // standby
    input wire logic wake_i,
    output logic standby_o,
    // status
    output logic [bit_literal_pkg::DATA_W-1:0] accum_o,
    output logic carry_o,
    output logic dcarry_o,
    output logic zero_o,
    output logic timeout_flag_o,
    output logic powerdown_flag_o
);
    import bit_literal_pkg::*;

    logic [1:0] phase_q; // oscillator period inside the cycle
    logic cyc_end; // last period, instruction retires here
    logic nop_q; // current cycle is the filler nop
    logic nop_adv_q; // filler nop steps past a discarded word
    logic exec; // a real instruction retires now
    logic [PC_W-1:0] pc_q;
    logic [DATA_W-1:0] w_q; // working accumulator
    logic carry_q, dcarry_q, zero_q;
    logic timeout_flag_q, powerdown_flag_q;
    logic standby_q;
    logic [DATA_W-1:0] pa_s1_q, pa_s2_q, pa_s3_q, pa_lvl_q; // port a sync
    logic [DATA_W-1:0] pb_s1_q, pb_s2_q, pb_s3_q, pb_lvl_q; // port b sync
    logic file_we_q, push_q, pop_q, presc_q, kick_q;
    logic [FA_W-1:0] waddr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [PC_W-1:0] ret_q;

    // decoded fields
    logic [FA_W-1:0] faddr;
    logic [BIT_W-1:0] bnum;
    logic [DATA_W-1:0] lit;
    logic [DATA_W-1:0] operand; // file byte or pin level
    logic [DATA_W-1:0] bit_mask;
    logic is_bit, is_call, is_jump, is_load, is_retv, is_or, is_and, is_xor, is_sub, is_add;
    logic is_andf, is_addf, is_sret, is_iret, is_stby, is_kick;
    logic dest_file, bit_val, skip_taken, pc_change;
    alu_op_e alu_op;
    logic [DATA_W-1:0] alu_res;
    logic alu_c, alu_dc, alu_z;
    logic wr_file; // retiring word writes a file register
    logic [DATA_W-1:0] wr_val;

    // cycle phase counter, instructions retire once per four clocks; pin synchronisers and side-effect registers step every clock
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            phase_q <= PHASE_FIRST;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end
    assign cyc_end = (phase_q == PHASE_LAST);
    assign exec = cyc_end && !nop_q && !standby_q;

    // pin synchronisers; a change is taken once stages two and three agree
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pa_s1_q <= DATA_ZERO;
            pa_s2_q <= DATA_ZERO;
            pa_s3_q <= DATA_ZERO;
            pa_lvl_q <= DATA_ZERO;
            pb_s1_q <= DATA_ZERO;
            pb_s2_q <= DATA_ZERO;
            pb_s3_q <= DATA_ZERO;
            pb_lvl_q <= DATA_ZERO;
        end else begin
            pa_s1_q <= port_a_pins_i;
            pa_s2_q <= pa_s1_q;
            pa_s3_q <= pa_s2_q;
            pb_s1_q <= port_b_pins_i;
            pb_s2_q <= pb_s1_q;
            pb_s3_q <= pb_s2_q;
            // per bit, so one settled pin is not held back by a moving one
            pa_lvl_q <= (pa_s2_q & ~(pa_s2_q ^ pa_s3_q)) | (pa_lvl_q & (pa_s2_q ^ pa_s3_q));
            pb_lvl_q <= (pb_s2_q & ~(pb_s2_q ^ pb_s3_q)) | (pb_lvl_q & (pb_s2_q ^ pb_s3_q));
        end
    end

    // instruction decode, words not listed here retire as single-cycle no-ops
    always_comb begin
        faddr = instr_i[FA_HI:0];
        bnum = instr_i[BNUM_HI:BNUM_LO];
        lit = instr_i[LIT_HI:0];
        dest_file = instr_i[DEST_BIT];
        is_bit = word_is(instr_i, PAT_BIT_GRP, CARE_GRP);
        is_call = word_is(instr_i, PAT_CALL, CARE_CTL);
        is_jump = word_is(instr_i, PAT_JUMP, CARE_CTL);
        is_load = word_is(instr_i, PAT_LOAD_IMM, CARE_LX2);
        is_retv = word_is(instr_i, PAT_RET_VAL, CARE_LX2);
        is_or = word_is(instr_i, PAT_OR_IMM, CARE_OP6);
        is_and = word_is(instr_i, PAT_AND_IMM, CARE_OP6);
        is_xor = word_is(instr_i, PAT_XOR_IMM, CARE_OP6);
        is_sub = word_is(instr_i, PAT_SUB_IMM, CARE_LX1);
        is_add = word_is(instr_i, PAT_ADD_IMM, CARE_LX1);
        is_andf = word_is(instr_i, PAT_AND_FILE, CARE_OP6);
        is_addf = word_is(instr_i, PAT_ADD_FILE, CARE_OP6);
        is_sret = word_is(instr_i, WORD_SUB_RET, CARE_ALL);
        is_iret = word_is(instr_i, WORD_INT_RET, CARE_ALL);
        is_stby = word_is(instr_i, WORD_STANDBY, CARE_ALL);
        is_kick = word_is(instr_i, WORD_WD_KICK, CARE_ALL);
    end

    // port reads see the pins, not the output latch
    always_comb begin
        if (faddr == PORT_A_ADDR) begin
            operand = pa_lvl_q;
        end else if (faddr == PORT_B_ADDR) begin
            operand = pb_lvl_q;
        end else begin
            operand = file_rdata_i;
        end
    end
    assign file_raddr_o = faddr;
    assign bit_mask = BIT_ONE << bnum;
    assign bit_val = |(operand & bit_mask);

    // skip and branch conditions
    always_comb begin
        skip_taken = 1'b0;
        if (is_bit && instr_i[BOP_HI:BOP_LO] == BOP_SKIP_LOW) begin
            skip_taken = !bit_val;
        end else if (is_bit && instr_i[BOP_HI:BOP_LO] == BOP_SKIP_HIGH) begin
            skip_taken = bit_val;
        end
        pc_change = is_call || is_jump || is_retv || is_sret || is_iret;
    end

    // arithmetic operation and operand choice
    always_comb begin
        if (is_add || is_addf) begin
            alu_op = ALU_ADD;
        end else if (is_sub) begin
            alu_op = ALU_SUB_B_A;
        end else if (is_and || is_andf) begin
            alu_op = ALU_AND;
        end else if (is_or) begin
            alu_op = ALU_OR;
        end else if (is_xor) begin
            alu_op = ALU_XOR;
        end else begin
            alu_op = ALU_PASS_B;
        end
    end

    alu_unit u_alu (
        .op_i(alu_op),
        .a_i(w_q),
        .b_i((is_andf || is_addf) ? operand : lit),
        .res_o(alu_res),
        .carry_o(alu_c),
        .dcarry_o(alu_dc),
        .zero_o(alu_z)
    );

    // file write-back value
    always_comb begin
        wr_file = 1'b0;
        wr_val = alu_res;
        if (is_bit && instr_i[BOP_HI:BOP_LO] == BOP_CLEAR) begin
            wr_file = 1'b1;
            wr_val = operand & ~bit_mask;
        end else if (is_bit && instr_i[BOP_HI:BOP_LO] == BOP_SET) begin
            wr_file = 1'b1;
            wr_val = operand | bit_mask;
        end else if ((is_andf || is_addf) && dest_file) begin
            wr_file = 1'b1;
        end
    end

    // program counter and the filler nop cycle
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pc_q <= PC_RESET;
            nop_q <= 1'b0;
            nop_adv_q <= 1'b0;
        end else if (cyc_end && nop_q) begin
            nop_q <= 1'b0;
            if (nop_adv_q) begin
                pc_q <= pc_q + PC_STEP; // step past the discarded word
            end
        end else if (exec) begin
            nop_q <= skip_taken || pc_change;
            nop_adv_q <= skip_taken;
            if (is_call || is_jump) begin
                pc_q <= instr_i[TGT_HI:0];
            end else if (is_retv || is_sret || is_iret) begin
                pc_q <= stack_top_i;
            end else begin
                pc_q <= pc_q + PC_STEP;
            end
        end
    end

    // accumulator and arithmetic flags; bit ops leave all flags alone
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            w_q <= DATA_ZERO;
            carry_q <= 1'b0;
            dcarry_q <= 1'b0;
            zero_q <= 1'b0;
        end else if (exec) begin
            if (is_add || is_sub || is_addf) begin
                carry_q <= alu_c;
                dcarry_q <= alu_dc;
            end
            if (is_add || is_sub || is_addf || is_and || is_andf || is_or || is_xor) begin
                zero_q <= alu_z;
            end
            if (is_add || is_sub || is_and || is_or || is_xor) begin
                w_q <= alu_res;
            end else if ((is_andf || is_addf) && !dest_file) begin
                w_q <= alu_res;
            end else if (is_load || is_retv) begin
                w_q <= lit;
            end
        end
    end

    // time-out and power-down, standby with wake
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            timeout_flag_q <= FLAG_IDLE;
            powerdown_flag_q <= FLAG_IDLE;
            standby_q <= 1'b0;
        end else if (exec && is_stby) begin
            timeout_flag_q <= 1'b1;
            powerdown_flag_q <= 1'b0;
            standby_q <= 1'b1;
        end else if (exec && is_kick) begin
            timeout_flag_q <= 1'b1;
            powerdown_flag_q <= 1'b1;
        end else if (cyc_end && standby_q && wake_i) begin
            standby_q <= 1'b0; // resume at the word after standby
        end
    end

    // one-clock side effects, registered so outputs do not glitch
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            file_we_q <= 1'b0;
            waddr_q <= '0;
            wdata_q <= DATA_ZERO;
            push_q <= 1'b0;
            pop_q <= 1'b0;
            ret_q <= PC_RESET;
            presc_q <= 1'b0;
            kick_q <= 1'b0;
        end else begin
            file_we_q <= exec && wr_file;
            push_q <= exec && is_call;
            pop_q <= exec && (is_retv || is_sret || is_iret);
            presc_q <= exec && wr_file && faddr == TIMER_ZERO_ADDR
                && prescaler_on_timer_i;
            kick_q <= exec && is_kick;
            if (exec) begin
                waddr_q <= faddr;
                wdata_q <= wr_val;
                ret_q <= pc_q + PC_STEP;
            end
        end
    end

    assign pc_o = pc_q;
    assign file_we_o = file_we_q;
    assign file_waddr_o = waddr_q;
    assign file_wdata_o = wdata_q;
    assign stack_push_o = push_q;
    assign stack_pop_o = pop_q;
    assign return_addr_o = ret_q;
    assign prescaler_clr_o = presc_q;
    assign watchdog_kick_o = kick_q;
    assign standby_o = standby_q;
    assign accum_o = w_q;
    assign carry_o = carry_q;
    assign dcarry_o = dcarry_q;
    assign zero_o = zero_q;
    assign timeout_flag_o = timeout_flag_q;
    assign powerdown_flag_o = powerdown_flag_q;

    // checks on retiring instructions
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    property p_bit_clear;
        exec && is_bit && instr_i[BOP_HI:BOP_LO] == BOP_CLEAR
            |=> file_we_o && (file_wdata_o & $past(bit_mask)) == DATA_ZERO && $stable(zero_q);
    endproperty
    a_bit_clear: assert property (p_bit_clear) else $error("bit clear wrong");
    property p_skip;
        exec && skip_taken |=> nop_q [*4] ##1 !nop_q;
    endproperty
    a_skip: assert property (p_skip) else $error("skip nop cycle wrong");
    property p_nop_len;
        exec && pc_change |=> (nop_q && !file_we_o) [*4] ##1 !nop_q;
    endproperty
    a_nop_len: assert property (p_nop_len) else $error("branch nop wrong");
    property p_add_imm;
        exec && is_add |=> w_q == 8'($past(w_q) + $past(lit));
    endproperty
    a_add_imm: assert property (p_add_imm) else $error("add immediate wrong");
    property p_and_imm;
        exec && is_and |=> w_q == ($past(w_q) & $past(lit)) && $stable(carry_q);
    endproperty
    a_and_imm: assert property (p_and_imm) else $error("and immediate wrong");
    property p_and_file;
        exec && is_andf && dest_file |=> file_we_o && $stable(w_q);
    endproperty
    a_and_file: assert property (p_and_file) else $error("and file dest wrong");
    property p_sub_imm;
        exec && is_sub |=> carry_q == ($past(lit) >= $past(w_q));
    endproperty
    a_sub_imm: assert property (p_sub_imm) else $error("sub carry wrong");
    property p_ret_val;
        exec && is_retv |=> stack_pop_o && nop_q && w_q == $past(lit);
    endproperty
    a_ret_val: assert property (p_ret_val) else $error("return value wrong");
    property p_standby;
        exec && is_stby |=> standby_o && timeout_flag_o && !powerdown_flag_o && !nop_q;
    endproperty
    a_standby: assert property (p_standby) else $error("standby wrong");
    property p_presc;
        exec && wr_file && faddr == TIMER_ZERO_ADDR && prescaler_on_timer_i |=> prescaler_clr_o;
    endproperty
    a_presc: assert property (p_presc) else $error("prescaler clear missing");
    property p_call;
        exec && is_call |=> stack_push_o && pc_o == $past(instr_i[TGT_HI:0]);
    endproperty
    a_call: assert property (p_call) else $error("call wrong");
    property p_phase;
        cyc_end |=> !cyc_end [*3] ##1 cyc_end;
    endproperty
    a_phase: assert property (p_phase) else $error("cycle length wrong");

    c_skip: cover property (exec && skip_taken);
    c_call: cover property (exec && is_call);
    c_port_write: cover property (exec && wr_file && faddr == PORT_B_ADDR);
    c_wake: cover property (standby_q ##[1:40] !standby_q);
endmodule : bit_literal_op_decoder

//--- hw/bit_literal_pkg.sv
package bit_literal_pkg;
    // word and datapath widths
    localparam int INSTR_W = 14; // program word
    localparam int PC_W = 11; // program counter, also the jump target width
    localparam int FA_W = 7; // file register address
    localparam int DATA_W = 8; // accumulator and file data
    localparam int BIT_W = 3; // bit number inside a file byte
    localparam int NIB_W = 4; // low nibble, digit carry boundary

    // instruction cycle: four oscillator periods
    localparam int PHASES = 4;
    localparam logic [1:0] PHASE_FIRST = 2'h0;
    localparam logic [1:0] PHASE_LAST = 2'(PHASES - 1);

    // field positions inside the word
    localparam int BOP_HI = 11; // bit group operation code
    localparam int BOP_LO = 10;
    localparam int BNUM_HI = 9; // bit number
    localparam int BNUM_LO = 7;
    localparam int DEST_BIT = 7; // destination select of byte ops
    localparam int FA_HI = 6; // file address
    localparam int LIT_HI = 7; // 8-bit literal
    localparam int TGT_HI = 10; // 11-bit target

    // bit group operation codes
    localparam logic [1:0] BOP_CLEAR = 2'h0;
    localparam logic [1:0] BOP_SET = 2'h1;
    localparam logic [1:0] BOP_SKIP_LOW = 2'h2;
    localparam logic [1:0] BOP_SKIP_HIGH = 2'h3;

    // match values and care masks
    localparam logic [13:0] CARE_GRP = 14'h3000;
    localparam logic [13:0] CARE_CTL = 14'h3800;
    localparam logic [13:0] CARE_LX2 = 14'h3c00;
    localparam logic [13:0] CARE_LX1 = 14'h3e00;
    localparam logic [13:0] CARE_OP6 = 14'h3f00;
    localparam logic [13:0] CARE_ALL = 14'h3fff;
    localparam logic [13:0] PAT_BIT_GRP = 14'h1000;
    localparam logic [13:0] PAT_CALL = 14'h2000;
    localparam logic [13:0] PAT_JUMP = 14'h2800;
    localparam logic [13:0] PAT_LOAD_IMM = 14'h3000;
    localparam logic [13:0] PAT_RET_VAL = 14'h3400;
    localparam logic [13:0] PAT_OR_IMM = 14'h3800;
    localparam logic [13:0] PAT_AND_IMM = 14'h3900;
    localparam logic [13:0] PAT_XOR_IMM = 14'h3a00;
    localparam logic [13:0] PAT_SUB_IMM = 14'h3c00;
    localparam logic [13:0] PAT_ADD_IMM = 14'h3e00;
    localparam logic [13:0] PAT_AND_FILE = 14'h0500;
    localparam logic [13:0] PAT_ADD_FILE = 14'h0700;
    localparam logic [13:0] WORD_SUB_RET = 14'h0008;
    localparam logic [13:0] WORD_INT_RET = 14'h0009;
    localparam logic [13:0] WORD_STANDBY = 14'h0063;
    localparam logic [13:0] WORD_WD_KICK = 14'h0064;

    // special file addresses
    localparam logic [6:0] TIMER_ZERO_ADDR = 7'h01;
    localparam logic [6:0] PORT_A_ADDR = 7'h05;
    localparam logic [6:0] PORT_B_ADDR = 7'h06;

    // reset values, pc step and single-bit mask
    localparam logic [10:0] PC_RESET = 11'h000;
    localparam logic [10:0] PC_STEP = 11'h001;
    localparam logic [7:0] DATA_ZERO = 8'h00;
    localparam logic [7:0] BIT_ONE = 8'h01;
    localparam logic FLAG_IDLE = 1'b1; // time-out and power-down after reset

    // arithmetic unit operations
    typedef enum logic [2:0] {
        ALU_PASS_B,
        ALU_ADD,
        ALU_AND,
        ALU_OR,
        ALU_XOR,
        ALU_SUB_B_A
    } alu_op_e;

    // word matches a pattern on its cared bits
    function automatic logic word_is(input logic [13:0] w, input logic [13:0] pat,
                                     input logic [13:0] care);
        return (w & care) == pat;
    endfunction : word_is
endpackage : bit_literal_pkg

//--- hw/alu_unit.sv
`timescale 1ns/1ps
module alu_unit
    import bit_literal_pkg::*;
(
    // operation and operands
    input wire bit_literal_pkg::alu_op_e op_i,
    input wire logic [bit_literal_pkg::DATA_W-1:0] a_i,
    input wire logic [bit_literal_pkg::DATA_W-1:0] b_i,
    // result and flags
    output logic [bit_literal_pkg::DATA_W-1:0] res_o,
    output logic carry_o,
    output logic dcarry_o,
    output logic zero_o
);
    import bit_literal_pkg::*;

    logic [DATA_W:0] sum; // ninth bit is carry out
    logic [NIB_W:0] nib; // fifth bit is digit carry
    logic [DATA_W-1:0] addend; // second adder input

    // one adder serves add and subtract; subtract is b + ~a + 1 so carry means no borrow
    always_comb begin
        addend = (op_i == ALU_SUB_B_A) ? ~a_i : a_i;
        sum = {1'b0, b_i} + {1'b0, addend} + {{DATA_W{1'b0}}, op_i == ALU_SUB_B_A};
        nib = {1'b0, b_i[NIB_W-1:0]} + {1'b0, addend[NIB_W-1:0]}
            + {{NIB_W{1'b0}}, op_i == ALU_SUB_B_A};
        case (op_i)
            ALU_ADD, ALU_SUB_B_A: res_o = sum[DATA_W-1:0];
            ALU_AND: res_o = a_i & b_i;
            ALU_OR: res_o = a_i | b_i;
            ALU_XOR: res_o = a_i ^ b_i;
            default: res_o = b_i;
        endcase
        carry_o = sum[DATA_W];
        dcarry_o = nib[NIB_W];
        zero_o = (res_o == DATA_ZERO);
    end
endmodule : alu_unit

//--- tb/prog_mem_model.sv
`timescale 1ns/1ps
// program memory, file registers and return stack outside the core
module prog_mem_model (
    // clock
    input wire logic sys_clk_i,
    // fetch
    input wire logic [10:0] pc_i,
    output logic [13:0] instr_o,
    // file access
    input wire logic [6:0] raddr_i,
    output logic [7:0] rdata_o,
    input wire logic we_i,
    input wire logic [6:0] waddr_i,
    input wire logic [7:0] wdata_i,
    // return stack
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic [10:0] ret_i,
    output logic [10:0] top_o
);
    logic [13:0] prog [0:2047]; // filled by the bench before reset ends
    logic [7:0] fram [0:127]; // file registers
    logic [10:0] stk [0:7]; // eight deep, wraps silently
    logic [2:0] sp_q = 3'h0; // next free slot
    // reads are combinational and hold while the address holds
    assign instr_o = prog[pc_i];
    assign rdata_o = fram[raddr_i];
    assign top_o = stk[sp_q - 3'h1];
    // writes and stack moves on the rising edge
    // plain always: the bench also preloads these arrays from its own process
    always @(posedge sys_clk_i) begin
        if (we_i) begin
            fram[waddr_i] <= wdata_i;
        end
        if (push_i) begin
            stk[sp_q] <= ret_i;
            sp_q <= sp_q + 3'h1;
        end else if (pop_i) begin
            sp_q <= sp_q - 3'h1;
        end
    end
endmodule : prog_mem_model

//--- tb/test_bit_literal_op_decoder.sv
`timescale 1ns/1ps
module test_bit_literal_op_decoder;
    import bit_literal_pkg::*;
    // expected pc, state word {w,c,dc,z,to,pd} and change cycle (0 = untimed)
    typedef struct {logic [10:0] pc; logic [12:0] st; int cyc;} note_s;
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic pre_on = 1'b1; // prescaler sits on the timer
    logic wake = 1'b1; // standby left at the first chance
    logic [7:0] pa = 8'h00;
    logic [7:0] pb = 8'hfe; // bit 0 low on the pins
    logic [13:0] instr;
    logic [10:0] pc, ret, top, last;
    logic [6:0] raddr, waddr;
    logic [7:0] rdata, wdata, accum, w, k, f20;
    logic we, push, pop, pre_clr, c, dc, z, to, pd, cf, dcf, zf, tof, pdf, timed, kick, stby;
    logic [8:0] s;
    note_s notes[$];
    note_s n;
    int num_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    int pre_cnt = 0;
    int kick_cnt = 0;
    int stby_cnt = 0;
    int t;
    logic [10:0] a;
    // 25 MHz core clock
    initial begin
        forever #20 sys_clk_i = ~sys_clk_i;
    end
    bit_literal_op_decoder uut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .instr_i(instr),
        .pc_o(pc), .file_raddr_o(raddr), .file_rdata_i(rdata), .file_we_o(we),
        .file_waddr_o(waddr), .file_wdata_o(wdata), .port_a_pins_i(pa), .port_b_pins_i(pb),
        .stack_push_o(push), .stack_pop_o(pop), .return_addr_o(ret), .stack_top_i(top),
        .prescaler_on_timer_i(pre_on), .prescaler_clr_o(pre_clr), .watchdog_kick_o(kick),
        .wake_i(wake), .standby_o(stby), .accum_o(accum), .carry_o(cf), .dcarry_o(dcf),
        .zero_o(zf), .timeout_flag_o(tof), .powerdown_flag_o(pdf));
    prog_mem_model mem (.sys_clk_i(sys_clk_i), .pc_i(pc), .instr_o(instr), .raddr_i(raddr),
        .rdata_o(rdata), .we_i(we), .waddr_i(waddr), .wdata_i(wdata), .push_i(push),
        .pop_i(pop), .ret_i(ret), .top_o(top));
    // one comparison, counted
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    // place a word, advance one cycle, note the pc it leads to
    task automatic put(input logic [13:0] wd, input logic [10:0] nxt);
        mem.prog[a] = wd;
        a = nxt;
        t += 4;
        notes.push_back('{a, {w, c, dc, z, to, pd}, timed ? t : 0});
    endtask : put
    // w plus k with all three flags
    task automatic add_k(input logic [7:0] v);
        s = {1'b0, w} + {1'b0, v};
        dc = ({1'b0, w[3:0]} + {1'b0, v[3:0]}) > 5'h0f;
        c = s[8];
        w = s[7:0];
        z = (w == 8'h00);
    endtask : add_k
    // clock cycle count since reset release
    always @(posedge sys_clk_i) begin
        if (rst_b_i) begin
            cyc++;
        end
    end
    // watcher: every pc change retires the oldest note
    always @(negedge sys_clk_i) begin
        pre_cnt += (rst_b_i && pre_clr === 1'b1) ? 1 : 0;
        kick_cnt += (rst_b_i && kick === 1'b1) ? 1 : 0;
        stby_cnt += (rst_b_i && stby === 1'b1) ? 1 : 0;
        if (rst_b_i && pc !== last && notes.size() > 0) begin
            n = notes.pop_front();
            check(24'(pc), 24'(n.pc));
            check(24'({accum, cf, dcf, zf, tof, pdf}), 24'(n.st));
            if (n.cyc > 0) begin
                check(24'(cyc), 24'(n.cyc));
            end
            $display("step to pc %h done", n.pc);
        end
        last = pc;
    end
    // program built with its expectations, then run
    initial begin
        void'($urandom(5));
        {w, c, dc, z, to, pd, timed, a, t} = {8'h00, 5'h03, 1'b1, 11'h000, 32'd0};
        for (int i = 0; i < 2048; i++) mem.prog[i] = 14'h0000;
        for (int i = 0; i < 128; i++) mem.fram[i] = 8'($urandom);
        mem.fram[6] = 8'hff; // latch disagrees with the pins
        pa = 8'($urandom);
        mem.fram[5] = ~pa;
        k = 8'($urandom); w = k; put(PAT_LOAD_IMM | 14'(k), a + 1);
        k = 8'($urandom); add_k(k); put(PAT_ADD_IMM | 14'(k), a + 1);
        k = 8'($urandom); s = {1'b0, k} - {1'b0, w}; c = ~s[8]; dc = k[3:0] >= w[3:0];
        w = s[7:0]; z = (w == 8'h00); put(PAT_SUB_IMM | 14'(k), a + 1);
        k = 8'($urandom); w = w & k; z = (w == 8'h00); put(PAT_AND_IMM | 14'(k), a + 1);
        k = 8'($urandom); w = w | k; z = (w == 8'h00); put(PAT_OR_IMM | 14'(k), a + 1);
        k = w; w = 8'h00; z = 1'b1; put(PAT_XOR_IMM | 14'(k), a + 1);
        k = 8'($urandom); w = k; put(PAT_LOAD_IMM | 14'(k), a + 1); // w not zero for the and
        f20 = mem.fram[32] & w; z = (f20 == 8'h00); put(PAT_AND_FILE | 14'h00a0, a + 1);
        add_k(mem.fram[33]); put(PAT_ADD_FILE | 14'h0021, a + 1);
        put(14'h1622, a + 1); // set bit 4 of 0x22
        put(14'h1e22, a + 1); // bit high: skip taken
        mem.prog[a] = 14'h30ff; t += 4; a++;
        notes.push_back('{a, {w, c, dc, z, to, pd}, t});
        put(14'h1a22, a + 1); // bit low test: falls through
        put(14'h1001, a + 1); // clear bit 0 of the timer count
        put(PAT_JUMP | 14'h0020, 11'h020); t += 4;
        put(PAT_CALL | 14'h0030, 11'h030); t += 4;
        k = 8'($urandom); w = k; put(PAT_RET_VAL | 14'(k), 11'h021); t += 4;
        pd = 1'b0; put(WORD_STANDBY, a + 1);
        timed = 1'b0; pd = 1'b1; put(WORD_WD_KICK, a + 1);
        put(14'h1806, a + 1); // port pin bit 0 low: skip taken
        t += 4; a++;
        notes.push_back('{a, {w, c, dc, z, to, pd}, 0});
        add_k(pa); put(PAT_ADD_FILE | 14'h0005, a + 1);
        put(PAT_CALL | 14'h0040, 11'h040); // plain return comes back to 0x27
        put(WORD_SUB_RET, 11'h027);
        put(PAT_CALL | 14'h0048, 11'h048);
        put(WORD_INT_RET, 11'h028);
        put(14'h1481, a + 1); // set bit 1 of the timer count, prescaler moved away
        last = 11'h000;
        repeat (2) @(negedge sys_clk_i);
        check(24'({pc, accum, cf, dcf, zf, tof, pdf}), 24'h000003);
        rst_b_i = 1'b1;
        while (notes.size() > 1) @(negedge sys_clk_i);
        pre_on = 1'b0; // the last timer write must leave the prescaler alone
        while (notes.size() != 0) @(negedge sys_clk_i);
        repeat (8) @(negedge sys_clk_i);
        check(24'(mem.fram[32]), 24'(f20));
        check(24'(mem.fram[34][4]), 24'h1);
        check(24'(mem.fram[1][0]), 24'h0);
        check(24'(pre_cnt), 24'h1);
        check(24'(mem.fram[1][1]), 24'h1);
        check(24'(kick_cnt), 24'h1);
        check(24'(stby_cnt), 24'(PHASES));
        complete_run();
    end
    // hang guard, far beyond the program length
    initial begin
        repeat (3000) @(posedge sys_clk_i);
        num_errors++;
        complete_run();
    end
endmodule : test_bit_literal_op_decoder
